// *** logic/fwp_pkg.sv ***
// package for the flash write-protect host controller
package fwp_pkg;
   // ==================================================================
   // command codes
   localparam logic [7:0] FWP_CMD_SET_WP    = 8'h57; // set write protect
   localparam logic [7:0] FWP_CMD_RESET_WP  = 8'h47; // reset write protect
   localparam logic [7:0] FWP_CMD_CONFIRM   = 8'hD0; // confirm code
   localparam logic [7:0] FWP_CMD_ERASE_ALL = 8'hA7; // erase all unlocked blocks
   localparam logic [7:0] FWP_CMD_CLR_STAT  = 8'h50; // clear status bits
   localparam logic [7:0] FWP_CMD_READ_ARR  = 8'hFF; // back to read array
   // ==================================================================
   // addresses and status fields
   localparam int         FWP_AW           = 10;           // address width driven
   localparam logic [9:0] FWP_ADDR_CONFIRM = 10'h0FF;      // confirm address
   localparam logic [9:0] FWP_ADDR_ANY     = 10'h000;      // don't-care address
   localparam int         FWP_ST_READY     = 7;            // ready bit
   localparam int         FWP_ST_ERR_HI    = 5;            // error bit 5
   localparam int         FWP_ST_ERR_LO    = 4;            // error bit 4
   localparam int         FWP_ST_VPP       = 3;            // low voltage bit
   // ==================================================================
   // bus timing: timer reload for 100 ns in clk_sys cycles, rounded up; each phase lasts one cycle more
   localparam int         FWP_PHASE_NS     = 100;
   localparam int         FWP_CLK_NS       = 4;
   localparam logic [7:0] FWP_PHASE_CYC    = 8'((FWP_PHASE_NS + FWP_CLK_NS - 1) / FWP_CLK_NS);
   // ==================================================================
   // user operations
   typedef enum logic [1:0] {
      FWP_OP_SET_WP,
      FWP_OP_RESET_WP,
      FWP_OP_ERASE_ALL,
      FWP_OP_CLEAR
   } fwp_op_t;
   // result of the last operation
   typedef struct packed {
      logic       vpp_low;  // prog_voltage_low_flag seen
      logic       seq_err;  // both error bits set
      logic       erase_err; // one error bit set
      logic       ok;       // both error bits clear
   } fwp_result_t;
   // device bus pins
   typedef struct packed {
      logic [9:0] addr;     // address
      logic       ce_n;     // chip enable, active low
      logic       we_n;     // write enable, active low
      logic       oe_n;     // output enable, active low
   } fwp_bus_t;
endpackage

// *** logic/fwp_host.sv ***
// host controller issuing write-protect, erase and status commands to the flash
// Overview of operation
// [R1] read error bits 4,5 after full erase
// [R2] low voltage: clear, reset protect, retry, set; the code only reports vpp_low, software does the recovery
// [R3] voltage fine: clear then retry erase; the code only reports erase_err, software clears and retries
// [R4] clear bits 3-5 before new attempts; the code clears them only when software issues FWP_OP_CLEAR
// [R5] set protect: 57H then D0H at 0FFH
// [R6] reset protect: 47H then D0H at 0FFH
// [R7] after power-up or powerdown toggle, set protect; the code only raises protect_needed until a set protect succeeds
// [R8] both error bits after protect: sequence error
// [R9] write FFH after last operation
// [R10] poll ready bit before and after; the code skips both polls for the clear op
// [R11] device holds errors until cleared
`timescale 1ns/1ps
`default_nettype none
module fwp_host
   import fwp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        op_valid,      // start an operation
   input  wire fwp_op_t     op_code,       // which operation
   output var  logic        op_ready,      // idle, will take op_valid
   output var  logic        done,          // one-cycle pulse at end
   output var  fwp_result_t result,        // status of last operation
   output var  logic [7:0]  status,        // last compat_status_reg read
   output var  fwp_bus_t    bus,           // address and strobes
   output var  logic [7:0]  dq_out,        // data driven to device
   output var  logic        dq_oe,         // high while host drives dq
   input  wire logic [7:0]  dq_in,         // data from device
   output var  logic        deep_powerdown_pin_n, // device reset pin, active low
   output var  logic        protect_needed // set protect owed after reset
);
   // ==================================================================
   // state machine
   typedef enum logic [3:0] {
      S_IDLE,  // waiting for an operation
      S_POLL1, // read status until ready, before any command
      S_WR1,   // first command write
      S_WR2,   // confirm write
      S_POLL2, // read status until the operation ends
      S_CLR,   // clear status write
      S_ARR,   // return to read array write
      S_DONE   // report the result
   } fwp_state_t;

   // registered state and pin images
   fwp_state_t  st_reg, st_next;
   logic [7:0]  tmr_reg;        // phase timer
   logic [1:0]  ph_reg;         // 0 setup, 1 strobe, 2 recovery
   fwp_op_t     op_reg;         // operation in progress
   fwp_bus_t    bus_reg;        // address and strobe images
   logic [7:0]  dq_reg;         // write data image
   logic        oe_reg;         // dq drive enable image
   logic [7:0]  stat_reg;       // status of the final poll
   logic [7:0]  poll_reg;       // byte caught in the read strobe
   fwp_result_t res_reg;        // decoded result
   logic        done_reg;       // end pulse
   logic        prot_reg;       // set protect still owed
   logic        rdy_reg;        // idle flag
   logic        rp_reg;         // power-down pin image

   wire         tick     = (tmr_reg == 8'h00);          // phase over
   wire         last_ph  = tick && (ph_reg == 2'd2);    // cycle over
   wire         is_read  = (st_reg == S_POLL1) || (st_reg == S_POLL2);
   wire         is_write = (st_reg == S_WR1) || (st_reg == S_WR2) ||
                           (st_reg == S_CLR) || (st_reg == S_ARR);
   wire         dev_rdy  = poll_reg[FWP_ST_READY];       // [R10]
   wire         start    = (st_reg == S_IDLE) && op_valid;
   // first command byte of each operation
   wire [7:0]   first_cmd = (op_reg == FWP_OP_SET_WP)   ? FWP_CMD_SET_WP :   // [R5]
                            (op_reg == FWP_OP_RESET_WP) ? FWP_CMD_RESET_WP : // [R6]
                            FWP_CMD_ERASE_ALL;
   // confirm goes to 0FFH for protect commands, anywhere for erase
   wire [9:0]   cfm_addr  = (op_reg == FWP_OP_ERASE_ALL) ? FWP_ADDR_ANY
                                                          : FWP_ADDR_CONFIRM; // [R5] [R6]
   wire [7:0]   wr_data   = (st_reg == S_WR1) ? first_cmd :
                            (st_reg == S_WR2) ? FWP_CMD_CONFIRM :
                            (st_reg == S_CLR) ? FWP_CMD_CLR_STAT :
                            FWP_CMD_READ_ARR;
   wire [9:0]   wr_addr   = (st_reg == S_WR2) ? cfm_addr : FWP_ADDR_ANY;
   wire         e_hi      = stat_reg[FWP_ST_ERR_HI];
   wire         e_lo      = stat_reg[FWP_ST_ERR_LO];

   // ==================================================================
   // next state
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         // a clear op has no device busy time, so it skips both polls
         S_IDLE:  if (op_valid) st_next = (op_code == FWP_OP_CLEAR) ? S_CLR : S_POLL1;
         // ready must show before issuing commands
         S_POLL1: if (last_ph && dev_rdy) st_next = S_WR1; // [R10]
         S_WR1:   if (last_ph) st_next = S_WR2;
         S_WR2:   if (last_ph) st_next = S_POLL2;
         // wait for the write_state_machine to finish
         S_POLL2: if (last_ph && dev_rdy) st_next = S_ARR; // [R10]
         // clear only bits 3-5 as a separate user op, so retry policy stays
         // with software which sees the result flags
         S_CLR:   if (last_ph) st_next = S_ARR; // [R4]
         S_ARR:   if (last_ph) st_next = S_DONE; // [R9]
         S_DONE:  st_next = S_IDLE;
         default: st_next = S_IDLE;
      endcase
   end

   // ==================================================================
   // state, op latch and phase timer
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_reg  <= S_IDLE;
         op_reg  <= FWP_OP_CLEAR;
         tmr_reg <= FWP_PHASE_CYC;
         ph_reg  <= 2'd0;
      end else begin
         st_reg <= st_next;
         if (start) op_reg <= op_code;
         // a state change restarts the phase count at setup
         if (st_next != st_reg) begin
            tmr_reg <= FWP_PHASE_CYC;
            ph_reg  <= 2'd0;
         end else if (tick) begin
            tmr_reg <= FWP_PHASE_CYC;
            ph_reg  <= (ph_reg == 2'd2) ? 2'd0 : ph_reg + 2'd1;
         end else begin
            tmr_reg <= tmr_reg - 8'h01;
         end
      end
   end

   // ==================================================================
   // pin drive: every bus cycle is three phases of equal length.
   //   phase 0, setup:    ce_n low, address and data settle
   //   phase 1, strobe:   we_n low for a write, oe_n low for a read
   //   phase 2, recovery: all strobes high, bus held quiet
   // the pin images are registered from ph_reg, so they trail the phase
   // counter by one clock; address and data stay put around both edges
   // of we_n because they only change with the state.
   // limitation: ce_n and we_n rise on the same edge, so a board that
   // needs we_n to lead ce_n must add its own delay on ce_n
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         bus_reg <= '{addr: FWP_ADDR_ANY, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
         dq_reg  <= 8'h00;
         oe_reg  <= 1'b0;
      end else begin
         bus_reg.addr <= is_write ? wr_addr : FWP_ADDR_ANY;
         bus_reg.ce_n <= !((is_write || is_read) && ph_reg != 2'd2);
         bus_reg.we_n <= !(is_write && ph_reg == 2'd1);
         // oe_n toggles each poll cycle so the device refreshes status
         bus_reg.oe_n <= !(is_read && ph_reg == 2'd1);
         dq_reg       <= wr_data;
         oe_reg       <= is_write;
      end
   end

   // ==================================================================
   // status sampler: the device only drives dq while ce_n and oe_n are
   // low, so the byte is caught in the last cycle of the strobe phase;
   // sampling later, once the strobes are back up, would read a
   // released bus and could take a floating line for ready
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         poll_reg <= 8'h00;
      end else if (is_read && tick && ph_reg == 2'd1) begin
         poll_reg <= dq_in; // [R10]
      end
   end

   // ==================================================================
   // status capture and result decode
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stat_reg <= 8'h00;
         res_reg  <= '0;
         done_reg <= 1'b0;
         rdy_reg  <= 1'b0;
      end else begin
         // the last ready poll carries the status of the finished operation
         if (st_reg == S_POLL2 && last_ph) stat_reg <= poll_reg;
         done_reg <= (st_reg == S_DONE);
         rdy_reg  <= (st_next == S_IDLE);
         if (st_reg == S_DONE && op_reg != FWP_OP_CLEAR) begin
            // device keeps stale errors until cleared, so result reflects them
            res_reg.ok        <= !e_hi && !e_lo;          // [R1] [R11]
            res_reg.erase_err <= e_hi ^ e_lo;             // [R1]
            res_reg.seq_err   <= e_hi && e_lo;            // [R1] [R8]
            res_reg.vpp_low   <= stat_reg[FWP_ST_VPP];    // [R2] [R3]
         end else if (st_reg == S_DONE) begin
            res_reg <= '0;
         end
      end
   end

   // ==================================================================
   // power-down pin and owed set-protect flag
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rp_reg   <= 1'b0;
         prot_reg <= 1'b1;
      end else begin
         rp_reg <= 1'b1;
         // any power-up leaves protection stale until set protect succeeds
         if (st_reg == S_DONE && op_reg == FWP_OP_SET_WP && !e_hi && !e_lo)
            prot_reg <= 1'b0; // [R7]
      end
   end

   // ==================================================================
   // outputs come straight from their registers
   assign op_ready             = rdy_reg;
   assign done                 = done_reg;
   assign result               = res_reg;
   assign status               = stat_reg;
   assign bus                  = bus_reg;
   assign dq_out               = dq_reg;
   assign dq_oe                = oe_reg;
   assign deep_powerdown_pin_n = rp_reg;
   assign protect_needed       = prot_reg;
endmodule
`default_nettype wire

// *** test/fwp_host_chk.sv ***
// assertion checker for the write-protect host controller
`timescale 1ns/1ps
`default_nettype none
module fwp_host_chk
   import fwp_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        op_valid,
   input wire fwp_op_t     op_code,
   input wire logic        op_ready,
   input wire logic        done,
   input wire fwp_result_t result,
   input wire logic [7:0]  status,
   input wire fwp_bus_t    bus,
   input wire logic [7:0]  dq_out,
   input wire logic        dq_oe,
   input wire logic [7:0]  dq_in,
   input wire logic        deep_powerdown_pin_n,
   input wire logic        protect_needed
);
   // ==========
   // handshake, strobe, result decode and power pin checks, all in the one clock domain
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   done_once_a: assert property (done |=> !done) else $error("done held too long");
   ready_back_a: assert property (done |-> op_ready) else $error("ready late");
   take_busy_a: assert property (op_valid && op_ready |=> !op_ready) else $error("not taken");
   no_fight_a: assert property (!bus.oe_n |-> !dq_oe && bus.we_n) else $error("dq fight");
   wr_drive_a: assert property (!bus.we_n |-> dq_oe && !bus.ce_n) else $error("bad write");
   we_width_a: assert property ($fell(bus.we_n) |-> !bus.we_n [*8]) else $error("short we");
   wr_hold_a:
      assert property (!bus.we_n |=> bus.we_n || $stable(dq_out) && $stable(bus.addr))
      else $error("write data moved");
   ok_bits_a: assert property (done && result.ok |-> status[5:4] == 2'h0)
      else $error("ok with error bits");
   seq_bits_a: assert property (done && result.seq_err |-> status[5:4] == 2'h3)
      else $error("sequence error misread");
   err_bits_a: assert property (done && result.erase_err |-> ^status[5:4])
      else $error("erase error misread");
   pin_up_a: assert property (resetn |=> deep_powerdown_pin_n) else $error("pin low");
   // main scenarios seen
   cover property (done && result.ok);
   cover property (done && result.seq_err);
   cover property (done && result.vpp_low);
endmodule
`default_nettype wire

// *** test/fwp_flash_model.sv ***
// behavioural flash device answering the host's bus cycles
`timescale 1ns/1ps
`default_nettype none
module fwp_flash_model
   import fwp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire fwp_bus_t   bus,
   input  wire logic [7:0] dq_out,
   input  wire logic       dq_oe,
   input  wire logic       pin_n,
   input  wire logic [1:0] fail_code, // 0 ok, 1 erase, 2 sequence, 3 low voltage
   output var  logic [7:0] dq_in,
   output var  logic       array_mode
);
   logic [7:0] stat_reg, pend_reg, last_reg, busy_reg; // status, open command, last dq, busy
   logic       we_q;
   wire        rd = !bus.ce_n && !bus.oe_n && !dq_oe;
   wire  [2:0] fault = fail_code == 2'h1 ? 3'h2 : fail_code == 2'h2 ? 3'h6 : {1'b0, {2{fail_code[0]}}};
   // released bus toggles, so a stale value never reads as good; erased array reads FF
   assign dq_in = rd ? (array_mode ? 8'hFF : {busy_reg == 8'h00, stat_reg[6:0]}) : ~last_reg;
   always @(posedge clk_sys) begin
      last_reg <= dq_in;
      we_q     <= bus.we_n;
      if (busy_reg == 8'h01) // errors are sticky until cleared
         stat_reg[5:3] <= stat_reg[5:3] | fault;
      if (busy_reg != 8'h00)
         busy_reg <= busy_reg - 8'h01;
      if (!pin_n) begin
         stat_reg   <= 8'h00;
         pend_reg   <= 8'h00;
         busy_reg   <= 8'h00;
         array_mode <= 1'b1;
      end else if (bus.we_n && !we_q) begin // write taken on rising strobe
         pend_reg   <= 8'h00;
         array_mode <= 1'b0;
         if (pend_reg == FWP_CMD_SET_WP || pend_reg == FWP_CMD_RESET_WP) begin
            if (dq_out == FWP_CMD_CONFIRM && bus.addr == FWP_ADDR_CONFIRM)
               busy_reg <= 8'hC8;
            else
               stat_reg[5:4] <= 2'h3;
         end else if (pend_reg == FWP_CMD_ERASE_ALL)
            busy_reg <= 8'hC8;
         else if (dq_out == FWP_CMD_CLR_STAT)
            stat_reg[5:3] <= 3'h0;
         else if (dq_out == FWP_CMD_READ_ARR)
            array_mode <= 1'b1;
         else
            pend_reg <= dq_out;
      end
   end
endmodule
`default_nettype wire

// *** test/fwp_host_tb_top.sv ***
// self-checking bench for the write-protect host controller
`timescale 1ns/1ps
`default_nettype none
module fwp_host_tb_top;
   import fwp_pkg::*;
   typedef struct packed {fwp_op_t op; logic [1:0] f; logic [3:0] res; logic [7:0] st;} fwp_row_t;
   logic clk_sys = 1'b0, resetn = 1'b0, op_valid = 1'b0, done, op_ready, dq_oe, pin_n, prot, arr;
   fwp_op_t op_code = FWP_OP_CLEAR;
   logic [1:0] fail = 2'h0;
   fwp_result_t result;
   fwp_bus_t bus;
   logic [7:0] status, dq_out, dq_in;
   int n_fail = 0, n_compared = 0;
   // op, injected fault, expected result, expected status
   fwp_row_t rows [10] = '{'{FWP_OP_SET_WP, 2'h0, 4'h1, 8'h80}, '{FWP_OP_RESET_WP, 2'h0, 4'h1, 8'h80},
      '{FWP_OP_ERASE_ALL, 2'h1, 4'h2, 8'h90}, '{FWP_OP_SET_WP, 2'h0, 4'h2, 8'h90},
      '{FWP_OP_CLEAR, 2'h0, 4'h0, 8'h00}, '{FWP_OP_ERASE_ALL, 2'h3, 4'hA, 8'h98},
      '{FWP_OP_CLEAR, 2'h0, 4'h0, 8'h00}, '{FWP_OP_RESET_WP, 2'h2, 4'h4, 8'hB0},
      '{FWP_OP_CLEAR, 2'h0, 4'h0, 8'h00}, '{FWP_OP_SET_WP, 2'h0, 4'h1, 8'h80}};
   always #2 clk_sys = ~clk_sys;
   fwp_host dut_u (.clk_sys, .resetn, .op_valid, .op_code, .op_ready, .done, .result, .status,
      .bus, .dq_out, .dq_oe, .dq_in, .deep_powerdown_pin_n(pin_n), .protect_needed(prot));
   fwp_flash_model dev_u (.clk_sys, .bus, .dq_out, .dq_oe, .pin_n, .fail_code(fail), .dq_in,
      .array_mode(arr));
   task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // issue one operation at a falling edge and wait for its done pulse
   task automatic run(fwp_op_t op, logic [1:0] f);
      int k;
      @(negedge clk_sys);
      for (k = 0; k < 100 && op_ready !== 1'b1; k++) @(negedge clk_sys);
      fail = f;
      op_code = op;
      op_valid = 1'b1;
      @(negedge clk_sys);
      op_valid = 1'b0;
      for (k = 0; k < 5000 && done !== 1'b1; k++) @(posedge clk_sys) #1;
      cmp("done", 8'h01, {7'h0, done});
   endtask
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_fail++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys) resetn = 1'b1;
      cmp("protect_needed", 8'h01, {7'h0, prot});
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].f);
         cmp("result", {4'h0, rows[i].res}, {4'h0, result});
         if (rows[i].op != FWP_OP_CLEAR) cmp("status", rows[i].st, status);
         cmp("array_mode", 8'h01, {7'h0, arr});
         $display("row %0d finished", i);
      end
      cmp("protect_needed", 8'h00, {7'h0, prot});
      // second reset in mid-run owes a fresh set protect
      @(negedge clk_sys) resetn = 1'b0;
      repeat (20) @(negedge clk_sys);
      cmp("powerdown_pin", 8'h00, {7'h0, pin_n});
      cmp("protect_needed", 8'h01, {7'h0, prot});
      resetn = 1'b1;
      run(FWP_OP_SET_WP, 2'h0);
      cmp("protect_needed", 8'h00, {7'h0, prot});
      $display("reset test finished");
      results();
   end
endmodule
bind fwp_host fwp_host_chk chk_u (.clk_sys, .resetn, .op_valid, .op_code, .op_ready, .done,
   .result, .status, .bus, .dq_out, .dq_oe, .dq_in, .deep_powerdown_pin_n, .protect_needed);
`default_nettype wire
